// ==== pisc_ctrl.sv ====
// pisc_ctrl: peripheral flags, core interrupt pending and vectoring, pin mux.
// assumes a core data-memory strobe port and a core register write port.
`timescale 1ns/100ps
`default_nettype none
module pisc_ctrl
   import pisc_pkg::*;
(
   input  wire logic            core_clk,
   input  wire logic            rst_b,
   input  wire logic            soft_rst,
   input  wire logic            wdog_rst,
   input  wire logic [AW-1:0]   dm_addr,
   input  wire logic [DW-1:0]   dm_wdata,
   input  wire logic            dm_wr,
   input  wire logic            dm_rd,
   output logic      [DW-1:0]   dm_rdata,
   input  wire logic [1:0]      creg_sel,
   input  wire logic            creg_wr,
   input  wire logic [DW-1:0]   creg_wdata,
   output logic      [DW-1:0]   creg_rdata,
   input  wire logic            timer_event,
   input  wire logic            ser_rx_irq,
   input  wire logic            ser_tx_irq,
   input  wire logic            irq_taken,
   input  wire logic            irq_return,
   output logic                 irq_req,
   output logic      [2:0]      irq_index,
   output logic      [AW-1:0]   irq_vector,
   output logic                 combined_peripheral_irq_n,
   input  wire logic            pwm_sync_pulse,
   input  wire logic            trip_pin_n,
   input  wire logic            overcurrent,
   input  wire logic [NPIO-1:0] pio_in,
   input  wire logic [NPIO-1:0] pio_is_input,
   input  wire logic            wdog_state,
   input  wire logic            pwm_timer_state,
   input  wire logic            receive_pin_first,
   input  wire logic            receive_pin_second,
   input  wire logic            transmit_frame_sync,
   input  wire logic            shared_pio_frame_pin_i,
   output logic                 shared_pio_frame_pin_o,
   output logic                 shared_pio_frame_pin_oe,
   input  wire logic            ser_tx_data,
   input  wire logic            core_flag_output,
   input  wire logic            flag_output_pin,
   output logic                 internal_receive_port,
   output logic                 internal_frame_sync,
   output logic                 flag_input_pin,
   output logic                 transmit_data_pin
);
   logic            prst;
   logic [15:0]     mask_q, sens_q, sys_q;
   logic [8:0]      mode_q, pen_q;
   logic [DW-1:0]   rdata_q, crd_q;
   logic            rd_st, rd_pl, rd_ph, wr_swt;
   logic [1:0]      st_set, st_clr, st_q;
   logic [8:0]      pio_set, pio_clr, pio_q;
   logic            sync_rise, trip_fall, sync_rise_x, sync_fall_x;
   logic [8:0]      pio_chg;
   logic            cpi_n_q;
   logic            alt, rxsel, uart, sel_rx;
   logic            line0_n, line1_n;
   logic [2:0]      ln_fall;
   logic [7:0]      pend_q, pend_set, pend_clr, eff_pend, msk, cand;
   logic [7:0]      act_q;
   logic            req_q;
   logic [2:0]      idx_q;
   logic [AW-1:0]   vec_q;
   logic            found;
   logic [2:0]      top;
   logic            allow;
   logic            rxp_q, rfs_q, fin_q, txd_q, spo_q, spoe_q;

   assign prst  = soft_rst | wdog_rst;
   assign rd_st = dm_rd && dm_addr == A_ST_FLAG;
   assign rd_pl = dm_rd && dm_addr == A_PIO_FLG_L;
   assign rd_ph = dm_rd && dm_addr == A_PIO_FLG_H;
   assign wr_swt = dm_wr && dm_addr == A_SW_TRIP && dm_wdata[0];

   // control registers back to reset on any reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_q  <= RST_SYS;
         mode_q <= RST_MODE;
         pen_q  <= RST_PEN;
      end else if (prst) begin
         sys_q  <= RST_SYS;
         mode_q <= RST_MODE;
         pen_q  <= RST_PEN;
      end else if (dm_wr) begin
         if (dm_addr == A_SYS_CTL) sys_q <= dm_wdata;
         if (dm_addr == A_MODE_CTL) mode_q <= dm_wdata[8:0];
         if (dm_addr == A_PIO_EN_L) pen_q[7:0] <= dm_wdata[7:0];
         if (dm_addr == A_PIO_EN_H) pen_q[8] <= dm_wdata[0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= RST_MASK;
         sens_q <= RST_SENS;
      end else if (prst) begin
         mask_q <= RST_MASK;
         sens_q <= RST_SENS;
      end else if (creg_wr) begin
         if (creg_sel == CR_MASK) mask_q <= creg_wdata;
         if (creg_sel == CR_SENS) sens_q <= creg_wdata;
      end
   end

   // sync rise, trip fall, sense or write
   pisc_edge #(.W(2), .INIT(2'b10)) u_pwm_edge (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .din      ({trip_pin_n, pwm_sync_pulse}),
      .rise     ({sync_rise_x, sync_rise}),
      .fall     ({trip_fall, sync_fall_x}),
      .change   ()
   );

   // any change of an enabled input
   pisc_edge #(.W(NPIO)) u_pio_edge (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .din      (pio_in),
      .rise     (),
      .fall     (),
      .change   (pio_chg)
   );

   assign st_set[FLG_SYNC] = sync_rise;
   assign st_set[FLG_TRIP] = trip_fall | overcurrent | wr_swt;
   assign st_clr  = {2{rd_st}};
   assign pio_set = pio_chg & pen_q & pio_is_input;
   assign pio_clr = {rd_ph, {8{rd_pl}}};

   // read clears both sync and trip
   pisc_flag #(.W(2)) u_st_flag (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .sync_rst (prst),
      .set      (st_set),
      .clr      (st_clr),
      .q        (st_q)
   );

   // pio flags cleared by their reads
   pisc_flag #(.W(NPIO)) u_pio_flag (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .sync_rst (prst),
      .set      (pio_set),
      .clr      (pio_clr),
      .q        (pio_q)
   );

   // combined line low while any flag pending
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpi_n_q <= 1'b1;
      end else begin
         cpi_n_q <= ~(|st_q | |pio_q);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 16'h0000;
      end else if (dm_rd) begin
         unique case (dm_addr)
            A_SYS_CTL:   rdata_q <= sys_q;
            A_MODE_CTL:  rdata_q <= {7'h00, mode_q};
            A_SYS_STAT:  rdata_q <= {13'h0000, pwm_timer_state, wdog_state,
                                     trip_pin_n};
            A_ST_FLAG:   rdata_q <= {14'h0000, st_q};
            A_PIO_FLG_L: rdata_q <= {8'h00, pio_q[7:0]};
            A_PIO_FLG_H: rdata_q <= {15'h0000, pio_q[8]};
            A_PIO_EN_L:  rdata_q <= {8'h00, pen_q[7:0]};
            A_PIO_EN_H:  rdata_q <= {15'h0000, pen_q[8]};
            default:     rdata_q <= 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         crd_q <= 16'h0000;
      end else begin
         unique case (creg_sel)
            CR_MASK: crd_q <= mask_q;
            CR_SENS: crd_q <= sens_q;
            default: crd_q <= 16'h0000;
         endcase
      end
   end

   // frame sync pins feed external lines in alternate config
   assign alt     = sys_q[SYS_ALT];
   assign line0_n = alt ? shared_pio_frame_pin_i : ~ser_rx_irq;
   assign line1_n = alt ? transmit_frame_sync : ~ser_tx_irq;

   pisc_edge #(.W(3), .INIT(3'b111)) u_line_edge (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .din      ({cpi_n_q, line1_n, line0_n}),
      .rise     (),
      .fall     (ln_fall),
      .change   ()
   );

   // force bits set, clear bits clear; only used sources take force
   always_comb begin
      pend_set = 8'h00;
      pend_clr = 8'h00;
      pend_set[PI_TIMER] = timer_event;
      pend_set[PI_RX]     = sens_q[0] & ln_fall[0];
      pend_set[PI_TX]     = sens_q[1] & ln_fall[1];
      pend_set[PI_PERIPH] = sens_q[2] & ln_fall[2];
      if (creg_wr && creg_sel == CR_FORCE) begin
         pend_set = pend_set | (creg_wdata[15:8] & PI_USED);
         pend_clr = creg_wdata[7:0];
      end
      if (irq_taken) begin
         pend_clr[idx_q] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= 8'h00;
      end else if (prst) begin
         pend_q <= 8'h00;
      end else begin
         pend_q <= pend_set | (pend_q & ~pend_clr);
      end
   end

   // level mode follows the line while low
   always_comb begin
      eff_pend = pend_q;
      eff_pend[PI_RX]     = pend_q[PI_RX] | (~sens_q[0] & ~line0_n);
      eff_pend[PI_TX]     = pend_q[PI_TX] | (~sens_q[1] & ~line1_n);
      eff_pend[PI_PERIPH] = pend_q[PI_PERIPH] | (~sens_q[2] & ~cpi_n_q);
      msk = 8'h00;
      msk[PI_TIMER]  = mask_q[MB_TIMER];
      msk[PI_RX]     = mask_q[MB_RX];
      msk[PI_TX]     = mask_q[MB_TX];
      msk[PI_SW0]    = mask_q[MB_SW0];
      msk[PI_SW1]    = mask_q[MB_SW1];
      // peripheral path gated by mask bit 9
      msk[PI_PERIPH] = mask_q[MASK_PERIPH];
      cand = eff_pend & msk;
   end

   always_comb begin
      found = 1'b0;
      top   = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (cand[i] && !found) begin
            found = 1'b1;
            top   = 3'(i);
         end
      end
      // nesting lets only higher ranks through
      if (sens_q[SENS_NEST]) begin
         allow = found && ((act_q >> top) == 8'h00);
      end else begin
         allow = found && (act_q == 8'h00);
      end
   end

   // active service levels for nesting
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         act_q <= 8'h00;
      end else if (prst) begin
         act_q <= 8'h00;
      end else if (irq_taken) begin
         act_q[idx_q] <= 1'b1;
      end else if (irq_return) begin
         // only the innermost (highest ranked) level ends on a return
         for (int j = 0; j < 8; j++) begin
            if (act_q[j] && ((act_q >> j) == 8'h01)) act_q[j] <= 1'b0;
         end
      end
   end

   // direct vector to the source slot
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_q <= 1'b0;
         idx_q <= 3'h0;
         vec_q <= 14'h0000;
      end else begin
         req_q <= allow && !irq_taken;
         idx_q <= top;
         unique case (top)
            PI_TIMER: vec_q <= V_TIMER;
            PI_RX:    vec_q <= V_RX;
            PI_TX:    vec_q <= V_TX;
            PI_SW0:   vec_q <= V_SW0;
            PI_SW1:   vec_q <= V_SW1;
            default:  vec_q <= st_q[FLG_TRIP] ? V_TRIP :
                               st_q[FLG_SYNC] ? V_SYNC :
                               |pio_q ? V_PIO : V_PERIPH;
         endcase
      end
   end

   // receive pin select; uart; alternate flag pins
   assign rxsel  = mode_q[MODE_RXSEL];
   assign uart   = mode_q[MODE_UART];
   assign sel_rx = rxsel ? receive_pin_second : receive_pin_first;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxp_q  <= 1'b0;
         rfs_q  <= 1'b0;
         fin_q  <= 1'b0;
         txd_q  <= 1'b0;
         spo_q  <= 1'b0;
         spoe_q <= 1'b0;
      end else begin
         rxp_q  <= sel_rx;
         rfs_q  <= uart ? sel_rx : shared_pio_frame_pin_i;
         fin_q  <= alt ? sel_rx : 1'b0;
         txd_q  <= alt ? flag_output_pin : ser_tx_data;
         spo_q  <= core_flag_output;
         spoe_q <= uart;
      end
   end

   assign dm_rdata                 = rdata_q;
   assign creg_rdata               = crd_q;
   assign irq_req                  = req_q;
   assign irq_index                = idx_q;
   assign irq_vector               = vec_q;
   assign combined_peripheral_irq_n = cpi_n_q;
   assign internal_receive_port    = rxp_q;
   assign internal_frame_sync      = rfs_q;
   assign flag_input_pin           = fin_q;
   assign transmit_data_pin        = txd_q;
   assign shared_pio_frame_pin_o   = spo_q;
   assign shared_pio_frame_pin_oe  = spoe_q;

   sequence s_st_read;
      rd_st && !(|st_set);
   endsequence

   property p_periph_mask;
      @(posedge core_clk) disable iff (!rst_b)
      req_q && idx_q == PI_PERIPH |-> $past(mask_q[MASK_PERIPH]);
   endproperty
   a_periph_mask: assert property (p_periph_mask)
      else $error("peripheral request without mask bit 9");

   property p_clear;
      @(posedge core_clk) disable iff (!rst_b || prst)
      creg_wr && creg_sel == CR_FORCE && creg_wdata[0] && !creg_wdata[8]
      && !timer_event |=> !pend_q[PI_TIMER];
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear bit did not clear timer pending");

   property p_soft_force;
      @(posedge core_clk) disable iff (!rst_b || prst)
      creg_wr && creg_sel == CR_FORCE && creg_wdata[11] |=> pend_q[PI_SW0];
   endproperty
   a_soft_force: assert property (p_soft_force)
      else $error("force bit 11 did not raise software interrupt");

   property p_nest_off;
      @(posedge core_clk) disable iff (!rst_b)
      req_q && !$past(sens_q[SENS_NEST]) |-> $past(act_q) == 8'h00;
   endproperty
   a_nest_off: assert property (p_nest_off)
      else $error("request while servicing with nesting off");

   property p_line_low;
      @(posedge core_clk) disable iff (!rst_b)
      (|st_q || |pio_q) |=> !cpi_n_q;
   endproperty
   a_line_low: assert property (p_line_low)
      else $error("combined line not low with flags pending");

   property p_st_ack;
      @(posedge core_clk) disable iff (!rst_b)
      s_st_read |=> st_q == 2'b00 ##1 cpi_n_q || |pio_q || |st_q;
   endproperty
   a_st_ack: assert property (p_st_ack)
      else $error("sync/trip read did not clear flags");

   property p_pio_ack;
      @(posedge core_clk) disable iff (!rst_b)
      rd_pl && !(|pio_set[7:0]) |=> pio_q[7:0] == 8'h00;
   endproperty
   a_pio_ack: assert property (p_pio_ack)
      else $error("pio low flags not cleared by read");

   property p_keep;
      @(posedge core_clk) disable iff (!rst_b || prst)
      rd_st && sync_rise |=> st_q[FLG_SYNC];
   endproperty
   a_keep: assert property (p_keep)
      else $error("sync event lost in clearing read");

   property p_rx_sel;
      @(posedge core_clk) disable iff (!rst_b)
      1'b1 |=> rxp_q == ($past(rxsel) ? $past(receive_pin_second)
                                      : $past(receive_pin_first));
   endproperty
   a_rx_sel: assert property (p_rx_sel)
      else $error("receive port follows wrong pin");

   property p_prio;
      @(posedge core_clk) disable iff (!rst_b)
      req_q |-> ($past(cand) >> idx_q) == 8'h01;
   endproperty
   a_prio: assert property (p_prio)
      else $error("request not the highest ranked source");
endmodule : pisc_ctrl
`default_nettype wire

// ==== pisc_pkg.sv ====
// pisc_pkg: constants for the peripheral interrupt and serial pin mux block.
// assumes a 16-bit core data bus with 14-bit data-memory addresses.
// How it works
// - force/clear register: bits 0-7 clear, bits 8-12 and 15 force core interrupts
// - software interrupts arise only from force bits 11 and 12
// - sensitivity bits 0-2 pick edge (set) or level (clear) per line
// - sensitivity bit 4 enables interrupt nesting
// - unmasked core interrupts vector straight to their own slot
// - peripheral events set flags; combined line low while any flag pending
// - simultaneous interrupts: highest priority source is served first
// - reading sync/trip flags clears both bits and acknowledges
// - reading the two pio flag registers clears them and acknowledges
// - hardware, software or watchdog reset returns control registers to reset
// - mode bit 4 picks second or first receive pin for the receive port
// - mode bit 5: uart emulation ties receive data to frame sync, flag out
// - system control bit 10: alternate config, receive pin as flag input
// - alternate config: frame syncs become external interrupt lines zero, one
// - status register shows trip pin, watchdog and pwm timer state
// - sync flagged on rising sync pulse; trip on falling pin, sense, write
// - pio event on any change of an enabled input line
package pisc_pkg;
   localparam int AW = 14;
   localparam int DW = 16;
   localparam int NPIO = 9;
   // data-memory addresses
   localparam logic [13:0] A_SYS_CTL   = 14'h3fff;
   localparam logic [13:0] A_MODE_CTL  = 14'h2015;
   localparam logic [13:0] A_SYS_STAT  = 14'h2016;
   localparam logic [13:0] A_ST_FLAG   = 14'h2017;
   localparam logic [13:0] A_PIO_FLG_L = 14'h2007;
   localparam logic [13:0] A_PIO_FLG_H = 14'h2047;
   localparam logic [13:0] A_PIO_EN_L  = 14'h2006;
   localparam logic [13:0] A_PIO_EN_H  = 14'h2046;
   localparam logic [13:0] A_SW_TRIP   = 14'h2061;
   // core register selects
   localparam logic [1:0] CR_MASK  = 2'h0;
   localparam logic [1:0] CR_FORCE = 2'h1;
   localparam logic [1:0] CR_SENS  = 2'h2;
   // field positions
   localparam int MASK_PERIPH = 9;
   localparam int SENS_NEST   = 4;
   localparam int MODE_RXSEL  = 4;
   localparam int MODE_UART   = 5;
   localparam int SYS_ALT     = 10;
   localparam int FORCE_BASE  = 8;
   localparam int FLG_SYNC    = 0;
   localparam int FLG_TRIP    = 1;
   // pending index equals priority rank, higher wins
   localparam logic [2:0] PI_TIMER  = 3'h0;
   localparam logic [2:0] PI_RX     = 3'h1;
   localparam logic [2:0] PI_TX     = 3'h2;
   localparam logic [2:0] PI_SW0    = 3'h3;
   localparam logic [2:0] PI_SW1    = 3'h4;
   localparam logic [2:0] PI_PERIPH = 3'h7;
   localparam logic [7:0] PI_USED   = 8'h9f;
   // mask bit of each pending index
   localparam int MB_TIMER = 0;
   localparam int MB_SW1   = 1;
   localparam int MB_SW0   = 2;
   localparam int MB_TX    = 3;
   localparam int MB_RX    = 4;
   // vector slots
   localparam logic [13:0] V_TRIP   = 14'h002c;
   localparam logic [13:0] V_PERIPH = 14'h0004;
   localparam logic [13:0] V_SYNC   = 14'h000c;
   localparam logic [13:0] V_PIO    = 14'h0008;
   localparam logic [13:0] V_SW1    = 14'h0018;
   localparam logic [13:0] V_SW0    = 14'h001c;
   localparam logic [13:0] V_TX     = 14'h0020;
   localparam logic [13:0] V_RX     = 14'h0024;
   localparam logic [13:0] V_TIMER  = 14'h0028;
   // reset values
   localparam logic [15:0] RST_MASK = 16'h0000;
   localparam logic [15:0] RST_SENS = 16'h0000;
   localparam logic [15:0] RST_SYS  = 16'h0000;
   localparam logic [8:0]  RST_MODE = 9'h000;
   localparam logic [8:0]  RST_PEN  = 9'h000;
endpackage : pisc_pkg

// ==== pisc_edge.sv ====
// pisc_edge: registered previous value with rise, fall and change outputs.
// assumes inputs synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module pisc_edge #(
   parameter int          W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall,
   output logic      [W-1:0] change
);
   logic [W-1:0] prev_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= INIT;
      end else begin
         prev_q <= din;
      end
   end

   assign rise   = din & ~prev_q;
   assign fall   = ~din & prev_q;
   assign change = din ^ prev_q;
endmodule : pisc_edge
`default_nettype wire

// ==== pisc_flag.sv ====
// pisc_flag: sticky flags, a set in the clearing cycle wins.
// assumes set and clr are one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module pisc_flag #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic         sync_rst,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else if (sync_rst) begin
         q <= '0;
      end else begin
         q <= set | (q & ~clr);
      end
   end
endmodule : pisc_flag
`default_nettype wire

// ==== pisc_seq_model.sv ====
// pisc_seq_model: sequencer stand-in that accepts core interrupt requests.
// assumes irq_req holds until irq_taken; lat sets how slowly it accepts.
`timescale 1ns/100ps
`default_nettype none
module pisc_seq_model (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        irq_req,
   input  wire logic [13:0] irq_vector,
   input  wire logic [3:0]  lat,
   output logic             irq_taken,
   output logic             irq_return,
   output logic      [13:0] vec_q
);
   logic [3:0] cnt_q;
   logic       busy_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q      <= 4'h0;
         busy_q     <= 1'b0;
         irq_taken  <= 1'b0;
         irq_return <= 1'b0;
         vec_q      <= 14'h0000;
      end else begin
         irq_taken  <= 1'b0;
         irq_return <= 1'b0;
         cnt_q      <= cnt_q + 4'h1;
         if (busy_q) begin
            if (cnt_q == 4'h6) begin
               irq_return <= 1'b1;
               busy_q     <= 1'b0;
            end
         end else if (!irq_req) begin
            cnt_q <= 4'h0;
         end else if (cnt_q >= lat) begin
            irq_taken <= 1'b1;
            vec_q     <= irq_vector;
            busy_q    <= 1'b1;
            cnt_q     <= 4'h0;
         end
      end
   end
endmodule : pisc_seq_model
`default_nettype wire

// ==== periph_irq_and_sport_mux_ctrl_bench.sv ====
// periph_irq_and_sport_mux_ctrl_bench: register and interrupt sequences.
// assumes pisc_ctrl and pisc_seq_model compiled before it.
`timescale 1ns/100ps
`default_nettype none
module periph_irq_and_sport_mux_ctrl_bench;
   import pisc_pkg::*;
   logic core_clk, rst_b, soft_rst, wdog_rst, dm_wr, dm_rd, creg_wr;
   logic [13:0] dm_addr, irq_vector, vec_q;
   logic [15:0] dm_wdata, dm_rdata, creg_wdata, creg_rdata;
   logic [1:0] creg_sel;
   logic [2:0] irq_index;
   logic [3:0] lat;
   logic [8:0] pio_in, pio_is_input;
   logic timer_event, ser_rx_irq, ser_tx_irq, irq_taken, irq_return, irq_req;
   logic combined_peripheral_irq_n, pwm_sync_pulse, trip_pin_n, overcurrent;
   logic wdog_state, pwm_timer_state, receive_pin_first, receive_pin_second;
   logic transmit_frame_sync, shared_pio_frame_pin_i, shared_pio_frame_pin_o;
   logic shared_pio_frame_pin_oe, ser_tx_data, core_flag_output;
   logic flag_output_pin, internal_receive_port, internal_frame_sync;
   logic flag_input_pin, transmit_data_pin;
   logic [13:0] vt [5] = '{V_TIMER, V_RX, V_TX, V_SW0, V_SW1};
   int num_errors = 0;
   int checks = 0;
   pisc_ctrl u_dut (.*);
   pisc_seq_model u_seq (.*);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task end_sim;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task wr(input logic [13:0] a, input logic [15:0] v);
      dm_addr = a; dm_wdata = v; dm_wr = 1'b1; cyc(1); dm_wr = 1'b0; cyc(1);
   endtask : wr
   task rc(input string n, input logic [13:0] a, input logic [15:0] e);
      dm_addr = a; dm_rd = 1'b1; cyc(1); dm_rd = 1'b0; chk(n, dm_rdata, e);
      cyc(1);
   endtask : rc
   task cw(input logic [1:0] s, input logic [15:0] v);
      creg_sel = s; creg_wdata = v; creg_wr = 1'b1; cyc(1);
      creg_wr = 1'b0; cyc(1);
   endtask : cw
   // waits for the sequencer to accept, then checks the slot it got
   task take(input logic [13:0] v);
      int i;
      i = 0;
      while (irq_taken !== 1'b1 && i < 40) begin cyc(1); i++; end
      chk("vector", {2'h0, vec_q}, {2'h0, v});
      chk("slot", {15'h0, vec_q > 14'h002f || vec_q[1:0] != 2'h0},
          16'h0);
      cyc(1);
   endtask : take
   initial begin
      #200000;
      num_errors++;
      end_sim;
   end
   initial begin
      {soft_rst, wdog_rst, dm_wr, dm_rd, creg_wr, dm_addr, dm_wdata} = '0;
      {creg_sel, creg_wdata, timer_event, ser_rx_irq, ser_tx_irq} = '0;
      {pwm_sync_pulse, overcurrent, pio_in, wdog_state, pwm_timer_state} = '0;
      {receive_pin_first, receive_pin_second} = '0;
      {ser_tx_data, core_flag_output, flag_output_pin, lat} = '0;
      {trip_pin_n, transmit_frame_sync, pio_is_input} = '1;
      shared_pio_frame_pin_i = 1'b1;
      rst_b = 1'b0;
      repeat (6) @(posedge core_clk);
      #1 rst_b = 1'b1;
      chk("line_rst", {15'h0, combined_peripheral_irq_n}, 16'h1);
      receive_pin_second = 1'b1;
      wr(A_MODE_CTL, 16'h0010);
      chk("rx_b", {15'h0, internal_receive_port}, 16'h1);
      core_flag_output = 1'b1;
      wr(A_MODE_CTL, 16'h0020);
      cyc(1);
      chk("rx_a", {15'h0, internal_receive_port}, 16'h0);
      chk("uart", {14'h0, shared_pio_frame_pin_oe, shared_pio_frame_pin_o},
          16'h3);
      chk("uart_fs", {15'h0, internal_frame_sync}, 16'h0);
      soft_rst = 1'b1; cyc(1); soft_rst = 1'b0; cyc(1);
      rc("mode", A_MODE_CTL, 16'h0000);
      receive_pin_first = 1'b1; flag_output_pin = 1'b1;
      wr(A_SYS_CTL, 16'h0400);
      cyc(1);
      chk("alt", {14'h0, flag_input_pin, transmit_data_pin}, 16'h3);
      cw(CR_MASK, 16'h001f);
      transmit_frame_sync = 1'b0;
      take(V_TX);
      transmit_frame_sync = 1'b1;
      wr(A_SYS_CTL, 16'h0000);
      pwm_sync_pulse = 1'b1; cyc(1); pwm_sync_pulse = 1'b0; cyc(5);
      chk("line", {15'h0, combined_peripheral_irq_n}, 16'h0);
      chk("req", {15'h0, irq_req}, 16'h0);
      cw(CR_MASK, 16'h021f);
      chk("mask_rd", creg_rdata, 16'h021f);
      take(V_SYNC);
      chk("index", {13'h0, irq_index}, {13'h0, PI_PERIPH});
      rc("flags", A_ST_FLAG, 16'h0001);
      cyc(2);
      chk("line", {15'h0, combined_peripheral_irq_n}, 16'h1);
      rc("flags2", A_ST_FLAG, 16'h0000);
      wr(A_SW_TRIP, 16'h0001);
      take(V_TRIP);
      rc("trip", A_ST_FLAG, 16'h0002);
      lat = 4'h5; trip_pin_n = 1'b0;
      take(V_TRIP);
      rc("trip_pin", A_ST_FLAG, 16'h0002);
      trip_pin_n = 1'b1; wdog_state = 1'b1; pwm_timer_state = 1'b1;
      dm_addr = A_SYS_STAT; dm_rd = 1'b1; cyc(1); dm_rd = 1'b0;
      chk("status", dm_rdata & 16'h0006, 16'h0006);
      wr(A_PIO_EN_H, 16'h0001);
      pio_in[8] = 1'b1;
      take(V_PIO);
      rc("pio_h", A_PIO_FLG_H, 16'h0001);
      rc("pio_l", A_PIO_FLG_L, 16'h0000);
      cyc(2);
      chk("line", {15'h0, combined_peripheral_irq_n}, 16'h1);
      pio_in[8] = 1'b0;
      take(V_PIO);
      rc("pio_fall", A_PIO_FLG_H, 16'h0001);
      rc("pio_l", A_PIO_FLG_L, 16'h0000);
      cyc(10);
      for (int i = 0; i < 5; i++) begin
         lat = 4'(i * 2);
         cw(CR_FORCE, 16'h0100 << i);
         take(vt[i]);
         cyc(8);
      end
      cw(CR_FORCE, 16'h1900);
      take(V_SW1);
      take(V_SW0);
      cw(CR_FORCE, 16'h0001);
      cyc(10);
      chk("cleared", {15'h0, irq_req}, 16'h0);
      // nesting on: a higher rank gets through while timer is serviced
      cw(CR_SENS, 16'h0010);
      lat = 4'h0;
      cw(CR_FORCE, 16'h0100);
      take(V_TIMER);
      cw(CR_FORCE, 16'h1000);
      chk("nest", {15'h0, irq_req}, 16'h1);
      take(V_SW1);
      cyc(10);
      // edge mode keeps a one-cycle line pulse that a slow accept misses
      lat = 4'h4;
      cw(CR_SENS, 16'h0001);
      ser_rx_irq = 1'b1; cyc(1); ser_rx_irq = 1'b0;
      take(V_RX);
      wdog_rst = 1'b1; cyc(2); wdog_rst = 1'b0;
      chk("wdog", creg_rdata, RST_SENS);
      end_sim;
   end
endmodule : periph_irq_and_sport_mux_ctrl_bench
`default_nettype wire
